// file: perf_event_params.svh
`ifndef PERF_EVENT_PARAMS_SVH
`define PERF_EVENT_PARAMS_SVH
// ----------------------------------------
// event codes, unit masks, counter indices and other shared constants
// ----------------------------------------
`define EVT_DTLB 8'h08
`define EVT_DISAMB 8'h09
`define EVT_WALK 8'h0c
`define EVT_FPCOMP 8'h10
`define EVT_FPASSIST 8'h11
`define EVT_PRODUCT 8'h12
`define UM_STORE_MISS 8'h08
`define UM_RESET 8'h01
`define UM_SUCCESS 8'h02
`define UM_WALK_COUNT 8'h01
`define UM_WALK_CYCLES 8'h02
`define UM_NONE 8'h00
`define CTR_ZERO 1'b0
`define CTR_ONE 1'b1
`define DISAMB_RESET_CYCLES 5'd20
`define CNT_WIDTH 4
`endif

// file: perf_event_pkg.sv
package perf_event_pkg;
  // decoded selection for one counter
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_STORE_MISS,
    SEL_DISAMB_RESET,
    SEL_DISAMB_OK,
    SEL_WALK_COUNT,
    SEL_WALK_CYCLES,
    SEL_FP_COMP,
    SEL_FLOAT_MICROCODE_HELP_EVT,
    SEL_PRODUCT
  } sel_t;
  typedef enum logic {
    FLUSH_IDLE,
    FLUSH_BUSY
  } flush_state_t;
endpackage

// file: perf_event_select_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_params.svh"
module perf_event_select_decode
  import perf_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selection for counter zero and counter one
  input wire logic [7:0] sel0_event,
  input wire logic [7:0] sel0_mask,
  input wire logic [7:0] sel1_event,
  input wire logic [7:0] sel1_mask,
  // pipeline status, one-cycle pulses except walk_busy
  input wire logic store_dtlb_miss,
  input wire logic disamb_mispredict,
  input wire logic load_disamb_ok,
  input wire logic walk_start,
  input wire logic walk_busy,
  input wire logic fp_comp_uop,
  input wire logic product_op,
  // assist sources
  input wire logic simd_fp_op,
  input wire logic simd_denormal_in,
  input wire logic simd_underflow,
  input wire logic denormal_inputs_as_zero_flag,
  input wire logic underflow_flush_flag,
  input wire logic stack_fp_op,
  input wire logic stack_nan_denorm_load,
  input wire logic stack_div_zero,
  input wire logic stack_underflow,
  // increments and flush status
  output logic inc_counter_zero,
  output logic inc_counter_one,
  output logic disamb_flush_active
);
  // ----------------------------------------
  // decoders, one per counter
  // ----------------------------------------
  perf_sel_if d0 ();
  perf_sel_if d1 ();
  assign d0.event_num = sel0_event;
  assign d0.unit_mask = sel0_mask;
  assign d0.counter_idx = `CTR_ZERO;
  assign d1.event_num = sel1_event;
  assign d1.unit_mask = sel1_mask;
  assign d1.counter_idx = `CTR_ONE;
  perf_sel_decode u_dec0 (.s(d0));
  perf_sel_decode u_dec1 (.s(d1));

  // ----------------------------------------
  // disambiguation flush timer
  // ----------------------------------------
  // a misprediction holds the flush for a fixed span; a new one restarts it
  flush_state_t state, next_state;
  logic [4:0] flush_cnt, next_flush_cnt;
  always_comb begin
    next_state = state;
    next_flush_cnt = flush_cnt;
    case (state)
      FLUSH_IDLE: begin
        if (disamb_mispredict) begin
          next_state = FLUSH_BUSY;
          next_flush_cnt = `DISAMB_RESET_CYCLES - 5'd1;
        end
      end
      FLUSH_BUSY: begin
        if (disamb_mispredict) begin
          next_flush_cnt = `DISAMB_RESET_CYCLES - 5'd1;
        end else if (flush_cnt == 5'd1) begin
          next_state = FLUSH_IDLE;
          next_flush_cnt = 5'd0;
        end else begin
          next_flush_cnt = flush_cnt - 5'd1;
        end
      end
      default: begin
        next_state = FLUSH_IDLE;
        next_flush_cnt = 5'd0;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FLUSH_IDLE;
      flush_cnt <= 5'd0;
    end else begin
      state <= next_state;
      flush_cnt <= next_flush_cnt;
    end
  end

  // ----------------------------------------
  // assist and event selection
  // ----------------------------------------
  logic assist;
  logic flushing;
  // flush cycles include the mispredict cycle itself
  assign flushing = disamb_mispredict || state == FLUSH_BUSY;
  always_comb begin
    assist = 1'b0;
    if (simd_fp_op) begin
      assist = (simd_denormal_in && !denormal_inputs_as_zero_flag) ||
               (simd_underflow && !underflow_flush_flag);
    end
    if (stack_fp_op) begin
      assist = assist || stack_nan_denorm_load || stack_div_zero ||
               stack_underflow;
    end
  end

  // shared by both counters
  function automatic logic pick(input sel_t s, input logic a);
    case (s)
      SEL_STORE_MISS: pick = store_dtlb_miss;
      SEL_DISAMB_RESET: pick = flushing;
      SEL_DISAMB_OK: pick = load_disamb_ok;
      SEL_WALK_COUNT: pick = walk_start;
      SEL_WALK_CYCLES: pick = walk_busy;
      SEL_FP_COMP: pick = fp_comp_uop;
      SEL_FLOAT_MICROCODE_HELP_EVT: pick = a;
      SEL_PRODUCT: pick = product_op;
      default: pick = 1'b0;
    endcase
  endfunction

  logic next_inc0, next_inc1;
  always_comb begin
    next_inc0 = pick(d0.sel, assist);
    next_inc1 = pick(d1.sel, assist);
  end
  // registered outputs: increment appears one cycle after the event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inc_counter_zero <= 1'b0;
      inc_counter_one <= 1'b0;
      disamb_flush_active <= 1'b0;
    end else begin
      inc_counter_zero <= next_inc0;
      inc_counter_one <= next_inc1;
      disamb_flush_active <= flushing;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_mispredict;
    disamb_mispredict && state == FLUSH_IDLE;
  endsequence
  // the whole twenty-cycle span, not just a prefix of it
  sequence s_flush_span;
    disamb_flush_active [*8] ##1 disamb_flush_active [*8] ##1
    disamb_flush_active [*4];
  endsequence
  chk_flush_span_len: assert property (@(posedge clk) disable iff (rst)
    s_mispredict |=> s_flush_span)
    else $error("flush span shorter than expected");
  chk_flush_end_bound: assert property (@(posedge clk) disable iff (rst)
    $fell(state == FLUSH_BUSY) |-> $past(flush_cnt) == 5'd1)
    else $error("flush ended early");
  chk_store_miss_cnt: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_DTLB && sel0_mask == `UM_STORE_MISS)
    |=> inc_counter_zero == $past(store_dtlb_miss))
    else $error("store miss not counted");
  chk_fpcomp_zero_only: assert property (@(posedge clk) disable iff (rst)
    (sel1_event == `EVT_FPCOMP) |=> !inc_counter_one)
    else $error("fp compute counted on counter one");
  chk_fpcomp_count: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_FPCOMP && sel0_mask == `UM_NONE)
    |=> inc_counter_zero == $past(fp_comp_uop))
    else $error("fp compute miscounted");
  chk_assist_one_only: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_FPASSIST) |=> !inc_counter_zero)
    else $error("assist counted on counter zero");
  chk_simd_assist: assert property (@(posedge clk) disable iff (rst)
    (sel1_event == `EVT_FPASSIST && simd_fp_op && simd_denormal_in &&
     !denormal_inputs_as_zero_flag) |=> inc_counter_one)
    else $error("simd denormal assist missed");
  chk_stack_assist: assert property (@(posedge clk) disable iff (rst)
    (sel1_event == `EVT_FPASSIST && stack_fp_op && stack_div_zero)
    |=> inc_counter_one)
    else $error("stack assist missed");
  chk_product_count: assert property (@(posedge clk) disable iff (rst)
    (sel1_event == `EVT_PRODUCT && sel1_mask == `UM_NONE)
    |=> inc_counter_one == $past(product_op))
    else $error("multiply miscounted");
  chk_walk_cycles: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_WALK && sel0_mask == `UM_WALK_CYCLES)
    |=> inc_counter_zero == $past(walk_busy))
    else $error("walk cycles miscounted");
  chk_walk_count: assert property (@(posedge clk) disable iff (rst)
    (sel1_event == `EVT_WALK && sel1_mask == `UM_WALK_COUNT)
    |=> inc_counter_one == $past(walk_start))
    else $error("walk starts miscounted");
  chk_disamb_ok: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_DISAMB && sel0_mask == `UM_SUCCESS)
    |=> inc_counter_zero == $past(load_disamb_ok))
    else $error("disambiguated loads miscounted");
  chk_reset_cycles: assert property (@(posedge clk) disable iff (rst)
    (sel0_event == `EVT_DISAMB && sel0_mask == `UM_RESET)
    |=> inc_counter_zero == disamb_flush_active)
    else $error("reset cycles miscounted");
endmodule
`default_nettype wire

// file: perf_sel_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_params.svh"
module perf_sel_decode
  import perf_event_pkg::*;
(
  perf_sel_if.dec s
);
  // ----------------------------------------
  // event/mask to selection
  // ----------------------------------------
  // restricted events decode to none on the wrong counter
  always_comb begin
    s.sel = SEL_NONE;
    case (s.event_num)
      `EVT_DTLB: begin
        if (s.unit_mask == `UM_STORE_MISS) s.sel = SEL_STORE_MISS;
      end
      `EVT_DISAMB: begin
        if (s.unit_mask == `UM_RESET) s.sel = SEL_DISAMB_RESET;
        else if (s.unit_mask == `UM_SUCCESS) s.sel = SEL_DISAMB_OK;
      end
      `EVT_WALK: begin
        if (s.unit_mask == `UM_WALK_COUNT) s.sel = SEL_WALK_COUNT;
        else if (s.unit_mask == `UM_WALK_CYCLES) s.sel = SEL_WALK_CYCLES;
      end
      `EVT_FPCOMP: begin
        if (s.unit_mask == `UM_NONE && s.counter_idx == `CTR_ZERO)
          s.sel = SEL_FP_COMP;
      end
      `EVT_FPASSIST: begin
        // unit mask not qualified for the assist event
        if (s.counter_idx == `CTR_ONE) s.sel = SEL_FLOAT_MICROCODE_HELP_EVT;
      end
      `EVT_PRODUCT: begin
        if (s.unit_mask == `UM_NONE && s.counter_idx == `CTR_ONE)
          s.sel = SEL_PRODUCT;
      end
      default: s.sel = SEL_NONE;
    endcase
  end
endmodule
`default_nettype wire

// file: perf_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface perf_sel_if;
  logic [7:0] event_num;
  logic [7:0] unit_mask;
  logic counter_idx;
  perf_event_pkg::sel_t sel;
  modport req (output event_num, output unit_mask, output counter_idx,
    input sel);
  modport dec (input event_num, input unit_mask, input counter_idx,
    output sel);
endinterface
`default_nettype wire

// file: tb_perf_event_select_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_params.svh"
module tb_perf_event_select_decode;
  import perf_event_pkg::*;
  // --------------------------------------------------------
  // clock, reset and stimulus
  // --------------------------------------------------------
  localparam int DLY = 5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sel0_event, sel0_mask, sel1_event, sel1_mask;
  logic store_dtlb_miss, disamb_mispredict, load_disamb_ok;
  logic walk_start, walk_busy, fp_comp_uop, product_op;
  logic simd_fp_op, simd_denormal_in, simd_underflow;
  logic denormal_inputs_as_zero_flag, underflow_flush_flag;
  logic stack_fp_op, stack_nan_denorm_load, stack_div_zero;
  logic stack_underflow;
  logic inc_counter_zero, inc_counter_one, disamb_flush_active;
  int fails = 0;
  int comparisons = 0;
  int c0, c1, cf;

  // 10 MHz core clock
  always #50 clk = ~clk;

  perf_event_select_decode i_perf_event_select_decode (
    .clk(clk), .rst(rst),
    .sel0_event(sel0_event), .sel0_mask(sel0_mask),
    .sel1_event(sel1_event), .sel1_mask(sel1_mask),
    .store_dtlb_miss(store_dtlb_miss),
    .disamb_mispredict(disamb_mispredict),
    .load_disamb_ok(load_disamb_ok), .walk_start(walk_start),
    .walk_busy(walk_busy), .fp_comp_uop(fp_comp_uop),
    .product_op(product_op), .simd_fp_op(simd_fp_op),
    .simd_denormal_in(simd_denormal_in),
    .simd_underflow(simd_underflow),
    .denormal_inputs_as_zero_flag(denormal_inputs_as_zero_flag),
    .underflow_flush_flag(underflow_flush_flag),
    .stack_fp_op(stack_fp_op),
    .stack_nan_denorm_load(stack_nan_denorm_load),
    .stack_div_zero(stack_div_zero),
    .stack_underflow(stack_underflow),
    .inc_counter_zero(inc_counter_zero),
    .inc_counter_one(inc_counter_one),
    .disamb_flush_active(disamb_flush_active));

  // --------------------------------------------------------
  // helpers
  // --------------------------------------------------------
  // one edge, then tally the settled registered outputs
  task step;
    @(posedge clk);
    #DLY;
    // an unknown output must not slip through a zero count
    if ($isunknown({inc_counter_zero, inc_counter_one,
        disamb_flush_active})) begin
      fails++;
      $display("ERROR %0t: unknown output", $time);
    end
    if (inc_counter_zero === 1'b1) c0++;
    if (inc_counter_one === 1'b1) c1++;
    if (disamb_flush_active === 1'b1) cf++;
  endtask
  task run(input int n);
    repeat (n) step();
  endtask
  task sel(input logic [7:0] e0, m0, e1, m1);
    {sel0_event, sel0_mask, sel1_event, sel1_mask} = {e0, m0, e1, m1};
    c0 = 0;
    c1 = 0;
    cf = 0;
  endtask
  // every status input low, so no stray increments leak between tests
  task idle;
    {store_dtlb_miss, disamb_mispredict, load_disamb_ok} = 3'h0;
    {walk_start, walk_busy, fp_comp_uop, product_op} = 4'h0;
    {simd_fp_op, simd_denormal_in, simd_underflow} = 3'h0;
    {denormal_inputs_as_zero_flag, underflow_flush_flag} = 2'h0;
    {stack_fp_op, stack_nan_denorm_load} = 2'h0;
    {stack_div_zero, stack_underflow} = 2'h0;
    sel(8'h00, 8'h00, 8'h00, 8'h00);
  endtask
  task check_count(input int got, input int exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s count %0d not %0d", $time, what, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s is %b not %b", $time, what, got, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------
  // scenarios
  // --------------------------------------------------------
  // wrong mask on counter one must stay silent
  task t_store_miss;
    sel(`EVT_DTLB, `UM_STORE_MISS, `EVT_DTLB, 8'h01);
    store_dtlb_miss = 1'b1;
    run(2);
    store_dtlb_miss = 1'b0;
    run(2);
    check_count(c0, 2, "store miss");
    check_count(c1, 0, "store miss bad mask");
    $display("test store_miss done");
  endtask
  task flush_pulse;
    disamb_mispredict = 1'b1;
    step();
    disamb_mispredict = 1'b0;
  endtask
  // single flush, then a second mispredict mid-flush restarts the span
  task t_disamb_reset;
    sel(`EVT_DISAMB, `UM_RESET, `EVT_DISAMB, `UM_SUCCESS);
    flush_pulse();
    run(25);
    check_count(c0, 20, "reset cycles");
    check_count(cf, 20, "flush span");
    sel(`EVT_DISAMB, `UM_RESET, `EVT_DISAMB, `UM_SUCCESS);
    flush_pulse();
    run(9);
    flush_pulse();
    run(40);
    check_count(c0, 30, "restarted reset cycles");
    check_count(c1, 0, "success during flush");
    $display("test disamb_reset done");
  endtask
  task t_disamb_ok;
    sel(`EVT_DISAMB, `UM_SUCCESS, `EVT_DISAMB, `UM_RESET);
    load_disamb_ok = 1'b1;
    run(3);
    load_disamb_ok = 1'b0;
    run(2);
    check_count(c0, 3, "disamb success");
    check_count(c1, 0, "no reset cycles");
    $display("test disamb_ok done");
  endtask
  task t_walks;
    sel(`EVT_WALK, `UM_WALK_COUNT, `EVT_WALK, `UM_WALK_CYCLES);
    walk_start = 1'b1;
    walk_busy = 1'b1;
    step();
    walk_start = 1'b0;
    run(4);
    walk_busy = 1'b0;
    run(2);
    check_count(c0, 1, "walks started");
    check_count(c1, 5, "walk cycles");
    // same walk with the two selections swapped between counters
    sel(`EVT_WALK, `UM_WALK_CYCLES, `EVT_WALK, `UM_WALK_COUNT);
    walk_start = 1'b1;
    walk_busy = 1'b1;
    step();
    walk_start = 1'b0;
    run(4);
    walk_busy = 1'b0;
    run(2);
    check_count(c0, 5, "walk cycles on zero");
    check_count(c1, 1, "walks started on one");
    $display("test walks done");
  endtask
  // right counters count, swapped counters never do
  task t_restrict;
    sel(`EVT_FPCOMP, `UM_NONE, `EVT_PRODUCT, `UM_NONE);
    {fp_comp_uop, product_op} = 2'h3;
    run(3);
    {fp_comp_uop, product_op} = 2'h0;
    run(1);
    check_count(c0, 3, "fp compute uops");
    check_count(c1, 3, "multiplies");
    sel(`EVT_PRODUCT, `UM_NONE, `EVT_FPCOMP, `UM_NONE);
    {fp_comp_uop, product_op} = 2'h3;
    run(3);
    {fp_comp_uop, product_op} = 2'h0;
    run(1);
    check_count(c0 + c1, 0, "swapped counters");
    // a nonzero unit mask is not a valid selection for these events
    sel(`EVT_FPCOMP, 8'h01, `EVT_PRODUCT, 8'h01);
    {fp_comp_uop, product_op} = 2'h3;
    run(2);
    {fp_comp_uop, product_op} = 2'h0;
    run(1);
    check_count(c0 + c1, 0, "nonzero unit mask");
    $display("test restrict done");
  endtask
  // every combination of assist sources and mode flags
  task automatic t_assist;
    logic [8:0] v;
    logic exp;
    sel(`EVT_FPASSIST, `UM_NONE, `EVT_FPASSIST, `UM_NONE);
    for (int i = 0; i < 512; i++) begin
      v = i[8:0];
      {simd_fp_op, simd_denormal_in, simd_underflow} = v[8:6];
      denormal_inputs_as_zero_flag = v[5];
      underflow_flush_flag = v[4];
      {stack_fp_op, stack_nan_denorm_load} = v[3:2];
      {stack_div_zero, stack_underflow} = v[1:0];
      exp = (v[8] & ((v[7] & ~v[5]) | (v[6] & ~v[4])))
        | (v[3] & (v[2] | v[1] | v[0]));
      step();
      check_bit(inc_counter_one, exp, "assist");
      check_bit(inc_counter_zero, 1'b0, "assist on zero");
    end
    idle();
    $display("test assist done");
  endtask

  // --------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------
  initial begin
    idle();
    repeat (4) @(posedge clk);
    #DLY;
    check_bit(inc_counter_zero, 1'b0, "in reset");
    rst = 1'b0;
    t_store_miss();
    t_disamb_reset();
    t_disamb_ok();
    t_walks();
    t_restrict();
    t_assist();
    conclude();
  end
  initial begin
    #(3000 * 100);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
